// ---- clock_mode_defines.vh ----
/*
  constants for the clock mode switch controller: field codes, multiplier
  tables, reference divider codes and settle counts.
  assumes inclusion by bare name from the design files.
*/
`ifndef CLOCK_MODE_DEFINES_VH
`define CLOCK_MODE_DEFINES_VH

// clock source select / clock status codes
`define CLOCK_SOURCE_SELECT_FLL          2'h0
`define CLOCK_SOURCE_SELECT_INTERNAL     2'h1
`define CLOCK_SOURCE_SELECT_EXTERNAL     2'h2
`define CLOCK_STATUS_PLL         2'h3

// fll multipliers, normal range
`define FLL_MUL_0         12'h280
`define FLL_MUL_1         12'h500
`define FLL_MUL_2         12'h780
`define FLL_MUL_3         12'ha00
// fll multipliers, 32.768 khz tuned range
`define FLL_MUL_T0        12'h2dc
`define FLL_MUL_T1        12'h5b8
`define FLL_MUL_T2        12'h895
`define FLL_MUL_T3        12'hb71

// vco divider code 0 multiplies by 24
`define VCO_MUL_BASE      6'h18

// reset values
`define RST_DCO_RANGE     2'h0
`define RST_FLL_REFERENCE_DIVIDER         3'h0
`define RST_PRDIV         5'h00
`define RST_VDIV          5'h00

// dco range change must land within three dco cycles
`define DCO_SWITCH_CYCLES 2'h3
// oscillator initialization cycles before ready is reported
`define OSC_INIT_CYCLES   12'hfff
// time taken by a source switch to complete, in ref_clk cycles
`define SWITCH_CYCLES     4'h4

`endif

// ---- clock_switch_sync.v ----
/*
  clock_switch_sync: holds a selection and moves to a newly requested one
  only after the target is available and a fixed switch time has elapsed.
  assumes request and availability are synchronous to ref_clk.
*/
`timescale 1ns/1ps
`include "clock_mode_defines.vh"

module clock_switch_sync #(
  parameter W = 2
) (
  // clock and reset
  input  wire         ref_clk,
  input  wire         rst,
  // selection
  input  wire [W-1:0] req_sel,
  input  wire         req_avail,
  input  wire [W-1:0] rst_sel,
  // result
  output reg  [W-1:0] cur_sel_ff,
  output reg          busy_ff
);

  reg [3:0] cnt_ff;
  reg [3:0] nxt_cnt;
  reg [W-1:0] nxt_sel;
  reg         nxt_busy;

  // a source that is not available leaves the previous one in place
  always @* begin
    nxt_cnt  = 4'h0;
    nxt_sel  = cur_sel_ff;
    nxt_busy = 1'b0;
    if (req_sel != cur_sel_ff && req_avail) begin
      nxt_busy = 1'b1;
      if (cnt_ff == `SWITCH_CYCLES - 4'h1) begin
        nxt_sel  = req_sel;
        nxt_busy = 1'b0;
      end else begin
        nxt_cnt = cnt_ff + 4'h1;
      end
    end
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      cnt_ff     <= 4'h0;
      cur_sel_ff <= rst_sel;
      busy_ff    <= 1'b0;
    end else begin
      cnt_ff     <= nxt_cnt;
      cur_sel_ff <= nxt_sel;
      busy_ff    <= nxt_busy;
    end
  end

endmodule // clock_switch_sync

// ---- oscillator_init_timer.v ----
/*
  oscillator_init_timer: counts initialization cycles of the external
  source once requested and stable; reports ready only afterwards.
  assumes osc_stable comes from the oscillator, synchronous to ref_clk.
*/
`timescale 1ns/1ps
`include "clock_mode_defines.vh"

module oscillator_init_timer (
  // clock and reset
  input  wire ref_clk,
  input  wire rst,
  // oscillator
  input  wire enable,
  input  wire osc_stable,
  // status
  output reg  ready_ff
);

  reg [11:0] cnt_ff;

  // any loss of request or stability restarts the count
  always @(posedge ref_clk) begin
    if (rst) begin
      cnt_ff   <= 12'h000;
      ready_ff <= 1'b0;
    end else if (!enable || !osc_stable) begin
      cnt_ff   <= 12'h000;
      ready_ff <= 1'b0;
    end else if (cnt_ff == `OSC_INIT_CYCLES) begin
      ready_ff <= 1'b1;
    end else begin
      cnt_ff <= cnt_ff + 12'h001;
    end
  end

endmodule // oscillator_init_timer

// ---- clock_mode_switch_control.v ----
/*
  clock_mode_switch_control: mode control of the multipurpose clock
  generator. selects the system output clock source, the fll reference,
  the internal oscillator and the loop multipliers and dividers, and
  reports each switch through status bits only once it has completed.
  assumes the analog loops, oscillators and clock muxes sit outside and
  follow the select outputs; all inputs are synchronous to ref_clk.
*/
`timescale 1ns/1ps
`include "clock_mode_defines.vh"

module clock_mode_switch_control (
  // clock and reset
  input  wire        ref_clk,
  input  wire        rst,
  // control one
  input  wire [1:0]  clock_source_select,
  input  wire [2:0]  fll_reference_divider,
  input  wire        reference_select,
  input  wire        internal_reference_enable,
  // control two
  input  wire        low_power_bypass_bit,
  input  wire        external_oscillator_request,
  input  wire        internal_reference_select,
  // control four
  input  wire [1:0]  dco_range_field,
  input  wire        dco_range_write,
  input  wire        tuning_32k_bit,
  // control five and six
  input  wire [4:0]  pll_reference_divider,
  input  wire        pll_select,
  input  wire [4:0]  vco_divider_field,
  // analog feedback
  input  wire        osc_stable,
  input  wire        pll_locked,
  input  wire        dco_tick,
  // status
  output reg  [1:0]  clock_status_ff,
  output reg         reference_status_ff,
  output reg         internal_select_status_ff,
  output reg         pll_source_status_ff,
  output reg         oscillator_ready_status_ff,
  output reg  [1:0]  dco_range_status_ff,
  // clock path controls
  output reg  [1:0]  out_mux_sel_ff,
  output reg         fll_use_internal_ff,
  output reg         fll_enable_ff,
  output reg         pll_enable_ff,
  output reg         internal_ref_run_ff,
  output reg         fast_internal_sel_ff,
  output reg  [11:0] fll_factor_ff,
  output reg  [5:0]  pll_factor_ff,
  output reg  [2:0]  fll_ref_div_ff,
  output reg  [4:0]  pll_ref_div_ff,
  output reg  [1:0]  dco_range_ff
);

  // fll factor from range code and tuning bit
  function [11:0] fll_factor;
    input [1:0] rng;
    input       tune;
    begin
      case ({tune, rng})
        3'h0:    fll_factor = `FLL_MUL_0;
        3'h1:    fll_factor = `FLL_MUL_1;
        3'h2:    fll_factor = `FLL_MUL_2;
        3'h3:    fll_factor = `FLL_MUL_3;
        3'h4:    fll_factor = `FLL_MUL_T0;
        3'h5:    fll_factor = `FLL_MUL_T1;
        3'h6:    fll_factor = `FLL_MUL_T2;
        3'h7:    fll_factor = `FLL_MUL_T3;
        default: fll_factor = `FLL_MUL_0;
      endcase
    end
  endfunction

  // local state
  reg [1:0] range_req_ff;
  reg [1:0] dco_cnt_ff;
  reg       range_pend_ff;
  wire      osc_ready;
  wire [1:0] src_cur;
  wire      src_busy;
  wire      ref_cur;
  wire      irc_cur;
  wire      pll_cur;

  oscillator_init_timer u_osc_timer (
    .ref_clk    (ref_clk),
    .rst        (rst),
    .enable     (external_oscillator_request),
    .osc_stable (osc_stable),
    .ready_ff   (osc_ready)
  );

  // system clock source; external needs the oscillator, fll slot needs the
  // pll locked when the pll is the chosen loop
  wire src_avail = (clock_source_select == `CLOCK_SOURCE_SELECT_EXTERNAL) ? osc_ready :
                   (clock_source_select == `CLOCK_SOURCE_SELECT_FLL && pll_cur) ? pll_locked : 1'b1;

  clock_switch_sync #(.W(2)) u_src_sw (
    .ref_clk    (ref_clk),
    .rst        (rst),
    .req_sel    (clock_source_select),
    .req_avail  (src_avail),
    .rst_sel    (`CLOCK_SOURCE_SELECT_FLL),
    .cur_sel_ff (src_cur),
    .busy_ff    (src_busy)
  );

  // fll reference: external needs the oscillator
  clock_switch_sync #(.W(1)) u_ref_sw (
    .ref_clk    (ref_clk),
    .rst        (rst),
    .req_sel    (reference_select),
    .req_avail  (reference_select | osc_ready),
    .rst_sel    (1'b1),
    .cur_sel_ff (ref_cur),
    .busy_ff    ()
  );

  clock_switch_sync #(.W(1)) u_irc_sw (
    .ref_clk    (ref_clk),
    .rst        (rst),
    .req_sel    (internal_reference_select),
    .req_avail  (1'b1),
    .rst_sel    (1'b0),
    .cur_sel_ff (irc_cur),
    .busy_ff    ()
  );

  // pll source needs the external oscillator when moving to the pll
  clock_switch_sync #(.W(1)) u_pll_sw (
    .ref_clk    (ref_clk),
    .rst        (rst),
    .req_sel    (pll_select),
    .req_avail  (~pll_select | osc_ready),
    .rst_sel    (1'b0),
    .cur_sel_ff (pll_cur),
    .busy_ff    ()
  );

  wire internal_mode = (src_cur == `CLOCK_SOURCE_SELECT_INTERNAL);
  wire fll_engaged   = (src_cur == `CLOCK_SOURCE_SELECT_FLL) && !pll_cur;

  always @(posedge ref_clk) begin
    if (rst) begin
      clock_status_ff            <= `CLOCK_SOURCE_SELECT_FLL;
      reference_status_ff        <= 1'b1;
      internal_select_status_ff  <= 1'b0;
      pll_source_status_ff       <= 1'b0;
      oscillator_ready_status_ff <= 1'b0;
      out_mux_sel_ff             <= `CLOCK_SOURCE_SELECT_FLL;
      fll_use_internal_ff        <= 1'b1;
      fll_enable_ff              <= 1'b1;
      pll_enable_ff              <= 1'b0;
      internal_ref_run_ff        <= 1'b1;
      fast_internal_sel_ff       <= 1'b0;
      fll_ref_div_ff             <= `RST_FLL_REFERENCE_DIVIDER;
      pll_ref_div_ff             <= `RST_PRDIV;
      pll_factor_ff              <= `VCO_MUL_BASE;
    end else begin
      // status follows completed switches only
      clock_status_ff            <= (src_cur == `CLOCK_SOURCE_SELECT_FLL && pll_cur) ? `CLOCK_STATUS_PLL : src_cur;
      reference_status_ff        <= ref_cur;
      internal_select_status_ff  <= irc_cur;
      pll_source_status_ff       <= pll_cur;
      oscillator_ready_status_ff <= osc_ready;
      out_mux_sel_ff             <= src_cur;
      fll_use_internal_ff        <= ref_cur;
      // fll stays on while bypassed unless low power or the pll is chosen
      fll_enable_ff              <= !pll_cur && (!low_power_bypass_bit || fll_engaged);
      pll_enable_ff              <= pll_cur && (!low_power_bypass_bit || src_cur == `CLOCK_SOURCE_SELECT_FLL);
      // internal reference runs when used, or on request in external modes
      internal_ref_run_ff        <= internal_mode || ref_cur || internal_reference_enable;
      fast_internal_sel_ff       <= irc_cur;
      fll_ref_div_ff             <= fll_reference_divider;
      pll_ref_div_ff             <= pll_reference_divider;
      pll_factor_ff              <= `VCO_MUL_BASE + {1'b0, vco_divider_field};
    end
  end

  // range writes accepted at any time except under low power
  always @(posedge ref_clk) begin
    if (rst) begin
      range_req_ff  <= `RST_DCO_RANGE;
      range_pend_ff <= 1'b0;
      dco_cnt_ff    <= 2'h0;
      dco_range_ff  <= `RST_DCO_RANGE;
      dco_range_status_ff <= `RST_DCO_RANGE;
      fll_factor_ff <= `FLL_MUL_0;
    end else begin
      if (dco_range_write && !low_power_bypass_bit) begin
        range_req_ff  <= dco_range_field;
        range_pend_ff <= 1'b1;
        dco_cnt_ff    <= 2'h0;
      end else if (range_pend_ff && dco_tick) begin
        // output lands on the new range by the third dco cycle
        if (dco_cnt_ff == `DCO_SWITCH_CYCLES - 2'h1) begin
          range_pend_ff <= 1'b0;
          dco_range_ff  <= range_req_ff;
        end else begin
          dco_cnt_ff <= dco_cnt_ff + 2'h1;
        end
      end
      dco_range_status_ff <= dco_range_ff;
      fll_factor_ff <= fll_factor(dco_range_ff, tuning_32k_bit);
    end
  end

endmodule // clock_mode_switch_control

// ---- clock_mode_switch_control_properties.sv ----
/*
  checker for clock_mode_switch_control: relations between its ports over time.
  assumes a bind to the design; every port lives in the ref_clk domain.
*/
`timescale 1ns/1ps
`include "clock_mode_defines.vh"

module clock_mode_switch_control_properties (
  // clock and reset
  input wire        ref_clk,
  input wire        rst,
  // controls
  input wire [1:0]  clock_source_select,
  input wire        reference_select,
  input wire        low_power_bypass_bit,
  input wire        external_oscillator_request,
  input wire        tuning_32k_bit,
  input wire        pll_select,
  input wire        osc_stable,
  input wire        dco_tick,
  // design outputs
  input wire [1:0]  clock_status_ff,
  input wire        reference_status_ff,
  input wire        pll_source_status_ff,
  input wire        oscillator_ready_status_ff,
  input wire [1:0]  out_mux_sel_ff,
  input wire        fll_enable_ff,
  input wire [11:0] fll_factor_ff,
  input wire [1:0]  dco_range_ff
);
  // multipliers indexed by {tuning, range}
  localparam logic [95:0] MUL_TBL = {12'hb71, 12'h895, 12'h5b8, 12'h2dc, 12'ha00, 12'h780, 12'h500, 12'h280};
  wire osc_go = osc_stable & external_oscillator_request;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  AST_RESET_STATE: assert property (disable iff (1'b0) rst |=> clock_status_ff == 2'h0 &&
    reference_status_ff && out_mux_sel_ff == 2'h0 && fll_enable_ff) else $error("reset state wrong");
  AST_INT_SWITCH: assert property ($rose(clock_status_ff == 2'h1) |-> out_mux_sel_ff == 2'h1 &&
    $past(clock_source_select, 1) == 2'h1 && $past(clock_source_select, 5) == 2'h1) else $error("early switch");
  AST_FLL_FACTOR: assert property (fll_factor_ff ==
    MUL_TBL[12 * {$past(tuning_32k_bit), $past(dco_range_ff)} +: 12]) else $error("fll factor wrong");
  AST_RANGE_TICK: assert property ($changed(dco_range_ff) |-> $past(dco_tick))
    else $error("range moved without dco tick");
  AST_OSC_READY: assert property ($rose(oscillator_ready_status_ff) |->
    $past(osc_go, 1) && $past(osc_go, 8)) else $error("ready too early");
  AST_OSC_DROP: assert property (!osc_go |-> ##2 !oscillator_ready_status_ff)
    else $error("ready held without oscillator");
  AST_REF_EXT: assert property ($fell(reference_status_ff) |->
    !$past(reference_select) && $past(oscillator_ready_status_ff)) else $error("reference switched early");
  AST_EXT_ROUTE: assert property (clock_status_ff == 2'h2 && !low_power_bypass_bit &&
    !$past(low_power_bypass_bit) |-> out_mux_sel_ff == 2'h2 && fll_enable_ff) else $error("external route wrong");
  AST_PLL_SRC: assert property ($rose(pll_source_status_ff) |->
    $past(pll_select) && $past(oscillator_ready_status_ff)) else $error("pll source too early");
endmodule // clock_mode_switch_control_properties

bind clock_mode_switch_control clock_mode_switch_control_properties i_props (
  .ref_clk, .rst, .clock_source_select, .reference_select, .low_power_bypass_bit,
  .external_oscillator_request, .tuning_32k_bit, .pll_select, .osc_stable, .dco_tick,
  .clock_status_ff, .reference_status_ff, .pll_source_status_ff, .oscillator_ready_status_ff,
  .out_mux_sel_ff, .fll_enable_ff, .fll_factor_ff, .dco_range_ff);

// ---- tb.sv ----
/*
  tb: self-checking bench for clock_mode_switch_control, walking the modes.
  assumes the design files and the checker file are compiled before it.
*/
`timescale 1ns/1ps
`include "clock_mode_defines.vh"

module tb;
  // clock, reset and one-bit controls
  logic        ref_clk, rst, reference_select, internal_reference_enable, low_power_bypass_bit;
  logic        external_oscillator_request, internal_reference_select, dco_range_write, tuning_32k_bit;
  logic        pll_select, osc_stable, pll_locked, dco_tick;
  // wide controls
  logic [1:0]  clock_source_select, dco_range_field;
  logic [2:0]  fll_reference_divider;
  logic [4:0]  pll_reference_divider, vco_divider_field;
  // outputs
  logic [1:0]  clock_status_ff, dco_range_status_ff, out_mux_sel_ff, dco_range_ff;
  logic        reference_status_ff, internal_select_status_ff, pll_source_status_ff;
  logic        oscillator_ready_status_ff, fll_use_internal_ff, fll_enable_ff, pll_enable_ff;
  logic        internal_ref_run_ff, fast_internal_sel_ff;
  logic [11:0] fll_factor_ff;
  logic [5:0]  pll_factor_ff;
  logic [2:0]  fll_ref_div_ff;
  logic [4:0]  pll_ref_div_ff;
  int          n_fail = 0;
  int          n_checks = 0;
  localparam logic [11:0] MUL [8] = '{12'h280, 12'h500, 12'h780, 12'ha00, 12'h2dc, 12'h5b8, 12'h895, 12'hb71};

  clock_mode_switch_control i_dut (
    .ref_clk, .rst, .clock_source_select, .fll_reference_divider, .reference_select,
    .internal_reference_enable, .low_power_bypass_bit, .external_oscillator_request,
    .internal_reference_select, .dco_range_field, .dco_range_write, .tuning_32k_bit,
    .pll_reference_divider, .pll_select, .vco_divider_field, .osc_stable, .pll_locked, .dco_tick,
    .clock_status_ff, .reference_status_ff, .internal_select_status_ff, .pll_source_status_ff,
    .oscillator_ready_status_ff, .dco_range_status_ff, .out_mux_sel_ff, .fll_use_internal_ff,
    .fll_enable_ff, .pll_enable_ff, .internal_ref_run_ff, .fast_internal_sel_ff, .fll_factor_ff,
    .pll_factor_ff, .fll_ref_div_ff, .pll_ref_div_ff, .dco_range_ff);

  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  // the range lands on the third dco tick, so ticks start only after the write edge
  task automatic wr_range(input logic [1:0] r);
    dco_range_field = r;
    dco_range_write = 1'b1;
    cyc(1);
    dco_range_write = 1'b0;
    repeat (3) begin
      dco_tick = 1'b1;
      cyc(1);
      dco_tick = 1'b0;
      cyc(1);
    end
    cyc(3);
  endtask

  task automatic give_verdict;
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // the run needs about 4400 cycles; a hang is cut off well beyond that
  initial begin
    #(20000 * 5);
    n_fail++;
    give_verdict;
  end

  initial begin
    {internal_reference_enable, low_power_bypass_bit, external_oscillator_request} = '0;
    {internal_reference_select, dco_range_write, tuning_32k_bit, pll_select, osc_stable} = '0;
    {pll_locked, dco_tick, clock_source_select, dco_range_field, fll_reference_divider} = '0;
    {pll_reference_divider, vco_divider_field} = '0;
    reference_select = 1'b1;
    rst = 1'b1;
    cyc(16);
    rst = 1'b0;
    cyc(1);
    chk(clock_status_ff, 2'h0);
    chk(reference_status_ff, 1'b1);
    chk(fll_factor_ff, 12'h280);
    for (int i = 0; i < 8; i++) begin
      tuning_32k_bit = i[2];
      wr_range(i[1:0]);
      chk(fll_factor_ff, MUL[i]);
      chk(dco_range_status_ff, i[1:0]);
    end
    low_power_bypass_bit = 1'b1;
    wr_range(2'h0);
    chk(dco_range_ff, 2'h3);
    chk(fll_factor_ff, 12'hb71);
    low_power_bypass_bit = 1'b0;
    tuning_32k_bit = 1'b0;
    clock_source_select = 2'h1;
    cyc(3);
    chk(clock_status_ff, 2'h0);
    cyc(4);
    chk(clock_status_ff, 2'h1);
    chk(out_mux_sel_ff, 2'h1);
    internal_reference_select = 1'b1;
    cyc(8);
    chk(internal_select_status_ff, 1'b1);
    chk(fast_internal_sel_ff, 1'b1);
    internal_reference_enable = 1'b1;
    external_oscillator_request = 1'b1;
    clock_source_select = 2'h2;
    cyc(20);
    chk(clock_status_ff, 2'h1);
    osc_stable = 1'b1;
    cyc(4000);
    chk(oscillator_ready_status_ff, 1'b0);
    cyc(200);
    chk(oscillator_ready_status_ff, 1'b1);
    chk(clock_status_ff, 2'h2);
    chk(fll_enable_ff, 1'b1);
    chk(internal_ref_run_ff, 1'b1);
    reference_select = 1'b0;
    cyc(8);
    chk(reference_status_ff, 1'b0);
    clock_source_select = 2'h0;
    fll_reference_divider = 3'h2;
    cyc(8);
    chk(fll_use_internal_ff, 1'b0);
    chk(out_mux_sel_ff, 2'h0);
    chk(fll_ref_div_ff, 3'h2);
    pll_reference_divider = 5'h01;
    vco_divider_field = 5'h02;
    pll_select = 1'b1;
    pll_locked = 1'b1;
    cyc(16);
    chk(pll_source_status_ff, 1'b1);
    chk(pll_factor_ff, 6'h1a);
    chk(pll_ref_div_ff, 5'h01);
    chk(clock_status_ff, 2'h3);
    chk(pll_enable_ff, 1'b1);
    osc_stable = 1'b0;
    cyc(3);
    chk(oscillator_ready_status_ff, 1'b0);
    rst = 1'b1;
    cyc(2);
    rst = 1'b0;
    cyc(1);
    chk(clock_status_ff, 2'h0);
    chk(reference_status_ff, 1'b1);
    give_verdict;
  end
endmodule // tb
